// *** design/rcr_reset_cause_recorder.sv ***
`timescale 1ns/1ps
module rcr_reset_cause_recorder (
	input  wire logic                  ref_clk,
	input  wire logic                  rst,
	input  wire logic                  pin_reset_n,
	input  wire rcr_pkg::rcr_sfr_req_t sfr_req,
	input  wire rcr_pkg::rcr_events_t  events,
	output logic [7:0]                 sfr_rdata,
	output logic                       sfr_rdata_valid,
	output logic                       sys_reset
);

	////////////////////////////////////////////////////////////////////////
	// Pin synchroniser; the first stage feeds only the second

	logic pin_meta_q;
	logic pin_sync_q;

	always_ff @(posedge ref_clk) begin
		pin_meta_q <= pin_reset_n;
		pin_sync_q <= pin_meta_q;
	end

	wire pin_asserted = !pin_sync_q;

	////////////////////////////////////////////////////////////////////////
	// Register decode

	wire reg_hit = sfr_req.addr == rcr_pkg::RCR_ADDR;
	wire reg_wr  = sfr_req.wr && reg_hit;
	wire reg_rd  = sfr_req.rd && reg_hit;

	////////////////////////////////////////////////////////////////////////
	// Enables; the flag state is kept apart from them so a write disturbs the
	// recorded cause only through BIT_SOFT.

	logic cmp_en_q;
	logic clk_en_q;
	logic sup_en_q;
	logic in_reset_q;

	// Only the writable positions are taken from the write data; apart from
	// BIT_SOFT, which forces a software reset, the read-only flag positions and the top bit reach no state.
	wire wr_cmp_en = sfr_req.wdata[rcr_pkg::BIT_CMP];
	wire wr_clk_en = sfr_req.wdata[rcr_pkg::BIT_CLK];
	wire wr_sup_en = sfr_req.wdata[rcr_pkg::BIT_POR];

	// Every system reset drops the source enables, so firmware has to re-arm
	// them; a write that lands while the reset is held is refused.
	wire en_clear  = rst || in_reset_q;
	wire en_load   = reg_wr && !in_reset_q;

	always_ff @(posedge ref_clk) begin
		if (en_clear) begin
			cmp_en_q <= rcr_pkg::ENABLE_RESET;
		end else if (en_load) begin
			cmp_en_q <= wr_cmp_en;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (en_clear) begin
			clk_en_q <= rcr_pkg::ENABLE_RESET;
		end else if (en_load) begin
			clk_en_q <= wr_clk_en;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (en_clear) begin
			sup_en_q <= rcr_pkg::ENABLE_RESET;
		end else if (en_load) begin
			sup_en_q <= wr_sup_en;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reset source detection

	wire flash_over  = events.flash_acc && (events.flash_addr > rcr_pkg::CODE_LIMIT);
	wire flash_fault = flash_over || events.flash_sec_fault;
	wire cmp_trip    = cmp_en_q && events.cmp_plus_lt_minus;
	wire clk_trip    = clk_en_q && events.clk_missing;
	wire sup_trip    = sup_en_q && events.supply_low;
	wire soft_trip   = reg_wr && sfr_req.wdata[rcr_pkg::BIT_SOFT];

	// Priority: power loss first, since other flags are meaningless after it
	rcr_pkg::rcr_cause_t cause_now;

	assign cause_now = (events.por || sup_trip) ? rcr_pkg::RCR_CAUSE_POR   :
	                   pin_asserted             ? rcr_pkg::RCR_CAUSE_PIN   :
	                   clk_trip                 ? rcr_pkg::RCR_CAUSE_CLK   :
	                   flash_fault              ? rcr_pkg::RCR_CAUSE_FLASH :
	                   events.wdog_ovf          ? rcr_pkg::RCR_CAUSE_WDOG  :
	                   cmp_trip                 ? rcr_pkg::RCR_CAUSE_CMP   :
	                   soft_trip                ? rcr_pkg::RCR_CAUSE_SOFT  :
	                                              rcr_pkg::RCR_CAUSE_NONE;

	wire trigger = cause_now != rcr_pkg::RCR_CAUSE_NONE;

	////////////////////////////////////////////////////////////////////////
	// Reset sequencer. A trigger holds the system reset for as long as it
	// lasts, then a fixed stretch follows, so downstream logic sees a clean
	// minimum-width reset even from a one-cycle software write.

	typedef enum logic [1:0] {
		SEQ_RUN,
		SEQ_HOLD,
		SEQ_STRETCH
	} rcr_seq_t;

	rcr_seq_t   seq_q;
	rcr_seq_t   seq_d;
	logic [3:0] pulse_q;
	logic [3:0] pulse_d;

	wire pulse_done = pulse_q == 4'h0;

	always_comb begin
		seq_d   = seq_q;
		pulse_d = pulse_q;
		case (seq_q)
			SEQ_RUN: begin
				if (trigger) begin
					seq_d   = SEQ_HOLD;
					pulse_d = rcr_pkg::PULSE_CYCLES;
				end
			end
			SEQ_HOLD: begin
				// A source that stays active keeps the count topped up
				if (trigger) begin
					pulse_d = rcr_pkg::PULSE_CYCLES;
				end else begin
					seq_d   = SEQ_STRETCH;
					pulse_d = pulse_q - 4'h1;
				end
			end
			SEQ_STRETCH: begin
				if (trigger) begin
					seq_d   = SEQ_HOLD;
					pulse_d = rcr_pkg::PULSE_CYCLES;
				end else if (pulse_done) begin
					seq_d   = SEQ_RUN;
				end else begin
					pulse_d = pulse_q - 4'h1;
				end
			end
			default: begin
				seq_d   = SEQ_RUN;
				pulse_d = '0;
			end
		endcase
	end

	// The reset output leaves a flop of its own, so it never glitches while
	// the sequencer changes state.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			seq_q      <= SEQ_RUN;
			pulse_q    <= '0;
			in_reset_q <= 1'b0;
		end else begin
			seq_q      <= seq_d;
			pulse_q    <= pulse_d;
			in_reset_q <= seq_d != SEQ_RUN;
		end
	end

	assign sys_reset = in_reset_q;

	////////////////////////////////////////////////////////////////////////
	// Cause flags; they survive the system reset they record. The local
	// rst is the recorder's own power-on reset.

	logic [6:0] cause_hot;
	wire  [6:0] cause_d;
	wire  [7:0] read_word;

	// One-hot image of the winning source, indexed by flag position
	always_comb begin
		cause_hot = '0;
		case (cause_now)
			rcr_pkg::RCR_CAUSE_POR:   cause_hot[rcr_pkg::BIT_POR]   = 1'b1;
			rcr_pkg::RCR_CAUSE_PIN:   cause_hot[rcr_pkg::BIT_PIN]   = 1'b1;
			rcr_pkg::RCR_CAUSE_CLK:   cause_hot[rcr_pkg::BIT_CLK]   = 1'b1;
			rcr_pkg::RCR_CAUSE_FLASH: cause_hot[rcr_pkg::BIT_FLASH] = 1'b1;
			rcr_pkg::RCR_CAUSE_WDOG:  cause_hot[rcr_pkg::BIT_WDOG]  = 1'b1;
			rcr_pkg::RCR_CAUSE_CMP:   cause_hot[rcr_pkg::BIT_CMP]   = 1'b1;
			rcr_pkg::RCR_CAUSE_SOFT:  cause_hot[rcr_pkg::BIT_SOFT]  = 1'b1;
			default:                  cause_hot = '0;
		endcase
	end

	// Every flag loads on a trigger, so the sources that lost are cleared on
	// the same edge that sets the winner; between triggers the word is frozen
	// and no write can reach it.
	for (genvar flag_idx = 0; flag_idx < rcr_pkg::BIT_UNUSED; flag_idx++) begin : g_flag
		logic flag_q;

		assign cause_d[flag_idx]   = trigger ? cause_hot[flag_idx] : flag_q;
		assign read_word[flag_idx] = flag_q;

		always_ff @(posedge ref_clk) begin
			if (rst) begin
				flag_q <= rcr_pkg::FLAGS_RESET[flag_idx];
			end else begin
				flag_q <= cause_d[flag_idx];
			end
		end
	end

	// The top bit has no storage behind it
	assign read_word[rcr_pkg::BIT_UNUSED] = 1'b0;

	////////////////////////////////////////////////////////////////////////
	// Read path; the word is captured on the strobe and then held, so the
	// value stays put even if a system reset lands right after the read.

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sfr_rdata       <= 8'h00;
			sfr_rdata_valid <= 1'b0;
		end else begin
			sfr_rdata_valid <= reg_rd;
			if (reg_rd) begin
				sfr_rdata <= read_word;
			end
		end
	end

endmodule // rcr_reset_cause_recorder

// *** design/rcr_pkg.sv ***
package rcr_pkg;

	// Special-function register address of the reset cause register
	localparam logic [7:0] RCR_ADDR       = 8'hef;

	// Bit positions inside the reset cause register
	localparam int         BIT_UNUSED     = 7;
	localparam int         BIT_FLASH      = 6;
	localparam int         BIT_CMP        = 5;
	localparam int         BIT_SOFT       = 4;
	localparam int         BIT_WDOG       = 3;
	localparam int         BIT_CLK        = 2;
	localparam int         BIT_POR        = 1;
	localparam int         BIT_PIN        = 0;

	// Reset values
	localparam logic [7:0] FLAGS_RESET    = 8'h02;
	localparam logic       ENABLE_RESET   = 1'b0;

	// Length of the stretch that keeps the system reset held after its trigger ends
	localparam int         PULSE_NS       = 64;
	localparam int         CLK_NS         = 8;
	localparam logic [3:0] PULSE_CYCLES   = 4'((PULSE_NS + CLK_NS - 1) / CLK_NS);

	// Flash user code space limit
	localparam logic [15:0] CODE_LIMIT    = 16'h3dff;

	// Cause encoding, latched while the system reset is held
	typedef enum logic [2:0] {
		RCR_CAUSE_NONE,
		RCR_CAUSE_PIN,
		RCR_CAUSE_POR,
		RCR_CAUSE_CLK,
		RCR_CAUSE_WDOG,
		RCR_CAUSE_SOFT,
		RCR_CAUSE_CMP,
		RCR_CAUSE_FLASH
	} rcr_cause_t;

	// Special-function register bus request
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rcr_sfr_req_t;

	// Raw reset event inputs, already on ref_clk
	typedef struct packed {
		logic        por;
		logic        supply_low;
		logic        wdog_ovf;
		logic        clk_missing;
		logic        cmp_plus_lt_minus;
		logic        flash_acc;
		logic        flash_sec_fault;
		logic [15:0] flash_addr;
	} rcr_events_t;

endpackage

// *** sim/rcr_reset_cause_recorder_assertions.sv ***
`timescale 1ns/1ps
module rcr_reset_cause_recorder_assertions (
	input wire logic                  ref_clk,
	input wire logic                  rst,
	input wire logic                  pin_reset_n,
	input wire rcr_pkg::rcr_sfr_req_t sfr_req,
	input wire rcr_pkg::rcr_events_t  events,
	input wire logic [7:0]            sfr_rdata,
	input wire logic                  sfr_rdata_valid,
	input wire logic                  sys_reset
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	wire rd_hit = sfr_req.rd && sfr_req.addr == rcr_pkg::RCR_ADDR;
	wire wr_hit = sfr_req.wr && sfr_req.addr == rcr_pkg::RCR_ADDR;
	////////////////////////////////
	a_read_answer: assert property (rd_hit |=> sfr_rdata_valid) else $error("read not answered");
	a_soft_force: assert property (wr_hit && sfr_req.wdata[rcr_pkg::BIT_SOFT] && !sys_reset |=> sys_reset)
		else $error("no soft reset");
	a_top_zero: assert property (sfr_rdata_valid |-> !sfr_rdata[rcr_pkg::BIT_UNUSED]) else $error("top bit set");
	// Every reset leaves exactly one cause behind
	a_one_cause: assert property (sfr_rdata_valid |-> $onehot(sfr_rdata)) else $error("cause not unique");
	a_pulse_hold: assert property ($rose(sys_reset) |-> sys_reset [*8]) else $error("reset pulse short");
	a_pin_reset: assert property (!pin_reset_n |-> ##[1:4] sys_reset) else $error("pin reset missed");
	a_flash_limit: assert property (events.flash_acc && events.flash_addr > rcr_pkg::CODE_LIMIT
		|-> ##[1:3] sys_reset) else $error("flash fault missed");
	a_por_reset: assert property (events.por |-> ##[1:3] sys_reset) else $error("power-on missed");
	cover property ($rose(sys_reset));
	cover property (sfr_rdata_valid && sfr_rdata[rcr_pkg::BIT_SOFT]);
	cover property (sfr_rdata_valid && sfr_rdata[rcr_pkg::BIT_PIN]);
endmodule // rcr_reset_cause_recorder_assertions

bind rcr_reset_cause_recorder rcr_reset_cause_recorder_assertions u_chk (.ref_clk(ref_clk), .rst(rst),
	.pin_reset_n(pin_reset_n), .sfr_req(sfr_req), .events(events), .sfr_rdata(sfr_rdata),
	.sfr_rdata_valid(sfr_rdata_valid), .sys_reset(sys_reset));

// *** sim/rcr_reset_cause_recorder_tb.sv ***
`timescale 1ns/1ps
module rcr_reset_cause_recorder_tb;
	logic                  ref_clk     = 1'b0;
	logic                  rst         = 1'b1;
	logic                  pin_reset_n = 1'b1;
	rcr_pkg::rcr_sfr_req_t req         = '0;
	rcr_pkg::rcr_events_t  ev          = '0;
	logic [7:0]            rdata;
	logic [7:0]            v;
	logic                  valid;
	logic                  sys_reset;
	int                    failures    = 0;
	int                    check_count = 0;
	always #4 ref_clk = ~ref_clk;
	rcr_reset_cause_recorder DUT (.ref_clk(ref_clk), .rst(rst), .pin_reset_n(pin_reset_n), .sfr_req(req),
		.events(ev), .sfr_rdata(rdata), .sfr_rdata_valid(valid), .sys_reset(sys_reset));
	////////////////////////////////
	task chk(input string n, input logic [7:0] s, input logic [7:0] e);
		check_count++;
		if (s !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task final_report();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Reads answer one cycle after the strobe; unmapped reads must stay silent
	task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk) req <= '{w, !w, a, d};
		@(posedge ref_clk) req <= '0;
		#1 v = rdata;
		if (!w) chk("valid", {7'h0, valid}, {7'h0, a == rcr_pkg::RCR_ADDR});
	endtask
	// Direct write only, never read-modify-write, then the selected event, if any, held two cycles
	task run(input logic [7:0] en, input int sel, input logic rs, input logic [7:0] exp);
		int n;
		acc(1'b1, rcr_pkg::RCR_ADDR, en);
		@(posedge ref_clk);
		case (sel)
			0: pin_reset_n <= 1'b0;
			1: ev.wdog_ovf <= 1'b1;
			2: ev.cmp_plus_lt_minus <= 1'b1;
			3: ev.clk_missing <= 1'b1;
			4: ev.supply_low <= 1'b1;
			5: ev <= rcr_pkg::rcr_events_t'({7'h02, 16'h3e00});
			6: ev <= rcr_pkg::rcr_events_t'({7'h02, 16'h3dff});
			7: ev.por <= 1'b1;
			8: ev <= rcr_pkg::rcr_events_t'({7'h01, 16'h0000});
			default: ;
		endcase
		repeat (2) @(posedge ref_clk);
		ev <= '0;
		pin_reset_n <= 1'b1;
		repeat (3) @(negedge ref_clk);
		chk("sys_reset", {7'h0, sys_reset}, {7'h0, rs});
		for (n = 0; n < 40 && sys_reset !== 1'b0; n++) @(negedge ref_clk);
		chk("reset released", {7'h0, sys_reset}, 8'h00);
		acc(1'b0, rcr_pkg::RCR_ADDR, 8'h00);
		chk("flags", v, exp);
		$display("test %0d done", sel);
	endtask
	////////////////////////////////
	initial begin
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		acc(1'b0, rcr_pkg::RCR_ADDR, 8'h00);
		chk("reset flags", v, rcr_pkg::FLAGS_RESET);
		acc(1'b0, 8'hee, 8'h00);
		$display("test reset done");
		run(8'h10, 9, 1'b1, 8'h10);
		run(8'h00, 1, 1'b1, 8'h08);
		run(8'h00, 8, 1'b1, 8'h40);
		run(8'h00, 0, 1'b1, 8'h01);
		run(8'h00, 6, 1'b0, 8'h01);
		run(8'h00, 5, 1'b1, 8'h40);
		run(8'h00, 2, 1'b0, 8'h40);
		run(8'h20, 2, 1'b1, 8'h20);
		acc(1'b1, rcr_pkg::RCR_ADDR, 8'h04);
		run(8'h00, 3, 1'b0, 8'h20);
		run(8'h04, 3, 1'b1, 8'h04);
		run(8'h00, 4, 1'b0, 8'h04);
		run(8'h02, 4, 1'b1, 8'h02);
		run(8'h00, 1, 1'b1, 8'h08);
		run(8'h00, 7, 1'b1, 8'h02);
		run(8'hc9, 9, 1'b0, 8'h02);
		final_report();
	end
	initial begin
		repeat (3000) @(posedge ref_clk);
		failures++;
		final_report();
	end
endmodule // rcr_reset_cause_recorder_tb
